// [src/chrs_top.sv]
/*
 Control-unit end of a parallel channel: disconnect and reset
 detection on the outbound tags, and status byte presentation.
 Assumes an AHB-Lite master with single word transfers and a channel
 that keeps its own tag timing.
*/
// Overview of operation
// - Address rise with hold low, or hold fall with address high, disconnects.
// - Operational-in drops well within 6 us after a disconnect.
// - Disconnect removes all inbound signals and clears command chaining.
// - A disconnect alone never creates status.
// - Disconnected busy device stays busy until device end accepted; idle stays idle.
// - Operational-out falling with suppress high is selective reset; drop operational-in.
// - Selective reset clears only the active device and status; path stays busy.
// - Resets keep ready state, except a held-off switch change applies.
// - Device end may follow a selective reset.
// - Both tags low while online is system reset; clear all, busy meanwhile.
// - Status in high puts the addressed device's status byte on bus in.
// - Status byte is parity then attention through unit exception.
// - Status is presented for selection, endings, stacked and asynchronous cases.
// - Not-ready to ready generates attention, control unit end, device end and unit exception.
// - Accepted status is cleared and never presented again.
// - Status is held until accepted or reset; refused status becomes stacked.
// - Status of a channel-initiated operation returns to its own channel.
// - Status is never hidden or merged; a byte generated while one is held is dropped and sets overrun.
// - Asynchronous device conditions raise attention.
// - Attention ends the operation and cancels command chaining.
`timescale 1ns/1ns
`default_nettype none
module chrs_top (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic select_out,
   input wire logic hold_out,
   input wire logic address_out,
   input wire logic command_out,
   input wire logic service_out,
   input wire logic suppress_out,
   input wire logic operational_out,
   input wire logic [7:0] bus_out,
   output logic operational_in,
   output logic address_in,
   output logic status_in,
   output logic request_in,
   output logic [8:0] bus_in
);
   import chrs_pkg::*;
   chrs_if cif ();
   logic [NTAG-1:0] tag_raw, t, tp_q;
   assign tag_raw = {operational_out, suppress_out, service_out, command_out,
                     address_out, hold_out, select_out};
   chrs_tag_qual u_qual (.clk_sys(clk_sys), .reset(reset), .tag_raw(tag_raw), .q(cif.qual));
   chrs_stat_store u_store (.clk_sys(clk_sys), .reset(reset), .s(cif.store));
   assign t = cif.tags;

   // AHB-Lite slave: one wait state so read data leaves a flop
   logic ph_q, ph_d, wt_q, wt_d, wr_q, wr_d;
   logic [7:0] ad_q, ad_d;
   logic [31:0] rd_q, rd_d;
   logic [31:0] state_word;
   logic wr_now;
   logic online_q, online_d, ready_sw_q, ready_sw_d, ready_q, ready_d;
   logic [7:0] devadr_q, devadr_d;
   always_comb begin
      ph_d = ph_q;
      wt_d = wt_q;
      wr_d = wr_q;
      ad_d = ad_q;
      rd_d = rd_q;
      if (ph_q && wt_q) begin
         wt_d = 1'b0;
         case (ad_q)
            OFS_CTRL: rd_d = {29'h0, 1'b0, ready_sw_q, online_q};
            OFS_DEVADR: rd_d = {24'h0, devadr_q};
            OFS_STATE: rd_d = state_word;
            OFS_SHOW: rd_d = {23'h0, ^cif.held == 1'b0, cif.held};
            default: rd_d = 32'h0000_0000;
         endcase
      end else if (ph_q) begin
         ph_d = 1'b0;
      end
      if (hready && hsel && htrans[1]) begin
         ph_d = 1'b1;
         wt_d = 1'b1;
         wr_d = hwrite;
         ad_d = haddr[7:0];
      end
   end
   always_ff @(posedge clk_sys) begin
      ph_q <= reset ? 1'b0 : ph_d;
      wt_q <= reset ? 1'b0 : wt_d;
      wr_q <= reset ? 1'b0 : wr_d;
      ad_q <= reset ? 8'h00 : ad_d;
      rd_q <= reset ? 32'h0000_0000 : rd_d;
   end
   assign hreadyout = !(ph_q && wt_q);
   assign hresp = 1'b0;
   assign hrdata = rd_q;
   assign wr_now = ph_q && !wt_q && wr_q;

   // Software-facing state; the unit reports busy for its whole system reset
   logic busy_q, busy_d, cc_q, cc_d;
   logic sys_rst, sel_rst, disc, conn;
   logic [6:0] rcnt_q, rcnt_d;
   chrs_state_e st_q, st_d;
   assign conn = operational_in;
   assign state_word = {24'h0, cif.overrun, ready_q, st_q == ST_RST, cc_q,
                        cif.stacked, cif.have, busy_q || st_q == ST_RST, operational_in};

   // Tag events, judged on qualified levels
   always_ff @(posedge clk_sys) begin
      tp_q <= reset ? '0 : t;
   end
   always_comb begin
      disc = conn && ((t[T_ADDR] && !tp_q[T_ADDR] && !t[T_HOLD]) ||
             (tp_q[T_HOLD] && !t[T_HOLD] && t[T_ADDR]));
      sel_rst = conn && tp_q[T_OPR] && !t[T_OPR] && t[T_SUP];
      sys_rst = online_q && !t[T_OPR] && !t[T_SUP];
   end

   // Device, switch and chaining state
   always_comb begin
      online_d = online_q;
      ready_sw_d = ready_sw_q;
      ready_d = ready_q;
      busy_d = busy_q;
      cc_d = cc_q;
      devadr_d = devadr_q;
      cif.gen = 1'b0;
      cif.gen_bits = 8'h00;
      if (wr_now && ad_q == OFS_CTRL) begin
         online_d = hwdata[C_ONLINE];
         ready_sw_d = hwdata[C_READY];
         if (hwdata[C_START] && !busy_q) begin
            busy_d = 1'b1;
            cc_d = 1'b1;
         end
      end
      if (wr_now && ad_q == OFS_DEVADR) begin
         devadr_d = hwdata[7:0];
      end
      if (wr_now && ad_q == OFS_GEN) begin
         cif.gen = 1'b1;
         cif.gen_bits = hwdata[7:0];
         if (hwdata[B_ATTN] && busy_q) begin
            busy_d = 1'b0;
            cc_d = 1'b0;
         end
      end
      // A switch change waits while busy, and one cycle behind a software byte
      if (ready_sw_q != ready_q && !busy_d && st_q != ST_RST && !cif.gen) begin
         ready_d = ready_sw_q;
         if (ready_sw_q) begin
            cif.gen = 1'b1;
            cif.gen_bits = RDY_STATUS;
         end
      end
      if (cif.accept && cif.held[B_DE]) begin
         busy_d = 1'b0;
      end
      if (cif.accept && ((cif.held & CHAIN_STOP) != 8'h00 || !t[T_SUP])) begin
         cc_d = 1'b0;
      end
      if (cif.stack || disc || sel_rst) begin
         cc_d = 1'b0;
      end
      if (st_q == ST_RST) begin
         busy_d = 1'b0;
         cc_d = 1'b0;
      end
   end
   always_ff @(posedge clk_sys) begin
      online_q <= reset ? 1'b0 : online_d;
      ready_sw_q <= reset ? 1'b0 : ready_sw_d;
      ready_q <= reset ? 1'b0 : ready_d;
      busy_q <= reset ? 1'b0 : busy_d;
      cc_q <= reset ? 1'b0 : cc_d;
      devadr_q <= reset ? 8'h00 : devadr_d;
   end

   // Connection sequence and inbound tags
   logic opi_d, adi_d, sti_d, rqi_d;
   logic opi_q, adi_q, sti_q, rqi_q;
   logic [8:0] bin_q, bin_d;
   always_comb begin
      st_d = st_q;
      rcnt_d = rcnt_q;
      opi_d = opi_q;
      adi_d = adi_q;
      sti_d = sti_q;
      rqi_d = cif.have && online_q && !conn && st_q == ST_IDLE;
      bin_d = bin_q;
      cif.accept = 1'b0;
      cif.stack = 1'b0;
      // Selective reset drops only the active device's status
      cif.clear = sel_rst || st_q == ST_RST;
      case (st_q)
         ST_IDLE: begin
            if (rqi_q && t[T_SEL] && t[T_HOLD] && !t[T_ADDR]) begin
               st_d = ST_ADR;
               opi_d = 1'b1;
               adi_d = 1'b1;
               bin_d = {^devadr_q == 1'b0, devadr_q};
            end
         end
         ST_ADR: begin
            if (t[T_CMD]) begin
               adi_d = 1'b0;
               bin_d = 9'h000;
               st_d = ST_REQ;
            end
         end
         ST_REQ: begin
            if (!t[T_CMD]) begin
               sti_d = 1'b1;
               bin_d = {^cif.held == 1'b0, cif.held};
               st_d = ST_STAT;
            end
         end
         ST_STAT: begin
            if (t[T_SRV]) begin
               cif.accept = 1'b1;
               sti_d = 1'b0;
               bin_d = 9'h000;
               st_d = ST_END;
            end else if (t[T_CMD]) begin
               cif.stack = 1'b1;
               sti_d = 1'b0;
               bin_d = 9'h000;
               st_d = ST_END;
            end
         end
         ST_END: begin
            if (!t[T_SRV] && !t[T_CMD] && !t[T_SEL]) begin
               opi_d = 1'b0;
               st_d = ST_IDLE;
            end
         end
         ST_RST: begin
            rcnt_d = rcnt_q + 7'h01;
            if (rcnt_q == 7'(RST_BUSY_CYC - 1) && !sys_rst) begin
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
      // Disconnect and resets drop operational in, address in, status in and bus in next cycle
      if (disc || sel_rst || sys_rst) begin
         opi_d = 1'b0;
         adi_d = 1'b0;
         sti_d = 1'b0;
         bin_d = 9'h000;
         st_d = sys_rst ? ST_RST : ST_IDLE;
         rcnt_d = sys_rst ? 7'h00 : rcnt_d;
      end
   end
   always_ff @(posedge clk_sys) begin
      st_q <= reset ? ST_IDLE : st_d;
      rcnt_q <= reset ? 7'h00 : rcnt_d;
      opi_q <= reset ? 1'b0 : opi_d;
      adi_q <= reset ? 1'b0 : adi_d;
      sti_q <= reset ? 1'b0 : sti_d;
      rqi_q <= reset ? 1'b0 : rqi_d;
      bin_q <= reset ? 9'h000 : bin_d;
   end
   assign operational_in = opi_q;
   assign address_in = adi_q;
   assign status_in = sti_q;
   assign request_in = rqi_q;
   assign bus_in = bin_q;
endmodule
`default_nettype wire

// [pkg/chrs_pkg.sv]
/*
 Shared constants of the channel reset and status logic: bus map,
 tag indices, status byte layout and timing counts.
 Assumes a single 125 MHz clock.
*/
package chrs_pkg;
   // Clock and tag timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int TAG_MIN_NS = 250;
   localparam int DROP_MAX_NS = 6000;
   localparam int TAG_MIN_CYC = (TAG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DROP_MAX_CYC = DROP_MAX_NS / CLK_PERIOD_NS;
   localparam int RST_BUSY_CYC = 64;
   // Outbound tag indices
   localparam int NTAG = 7;
   localparam int T_SEL = 0;
   localparam int T_HOLD = 1;
   localparam int T_ADDR = 2;
   localparam int T_CMD = 3;
   localparam int T_SRV = 4;
   localparam int T_SUP = 5;
   localparam int T_OPR = 6;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DEVADR = 8'h04;
   localparam logic [7:0] OFS_GEN = 8'h08;
   localparam logic [7:0] OFS_STATE = 8'h0C;
   localparam logic [7:0] OFS_SHOW = 8'h10;
   // Control fields
   localparam int C_ONLINE = 0;
   localparam int C_READY = 1;
   localparam int C_START = 2;
   // State fields
   localparam int S_OPIN = 0;
   localparam int S_BUSY = 1;
   localparam int S_PEND = 2;
   localparam int S_STACK = 3;
   localparam int S_CC = 4;
   localparam int S_RESET = 5;
   localparam int S_READY = 6;
   localparam int S_OVR = 7;
   // Status byte: bit 0 on the wire is the top index
   localparam int B_ATTN = 7;
   localparam int B_SM = 6;
   localparam int B_CUE = 5;
   localparam int B_BUSY = 4;
   localparam int B_CE = 3;
   localparam int B_DE = 2;
   localparam int B_UC = 1;
   localparam int B_UE = 0;
   localparam int B_PAR = 8;
   localparam logic [7:0] RDY_STATUS = 8'hA5;
   localparam logic [7:0] CHAIN_STOP = 8'hF3;
   typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_ADR, ST_STAT, ST_END, ST_RST} chrs_state_e;
endpackage

// [pkg/chrs_if.sv]
/*
 Carrier between the core, the tag qualifier and the status store.
 Assumes all members run on the one system clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface chrs_if;
   import chrs_pkg::*;
   logic [NTAG-1:0] tags;
   logic gen;
   logic [7:0] gen_bits;
   logic clear;
   logic accept;
   logic stack;
   logic have;
   logic stacked;
   logic [7:0] held;
   logic overrun;
   modport qual (output tags);
   modport store (input gen, gen_bits, clear, accept, stack,
      output have, stacked, held, overrun);
   modport core (input tags, have, stacked, held, overrun,
      output gen, gen_bits, clear, accept, stack);
endinterface
`default_nettype wire

// [src/chrs_tag_qual.sv]
/*
 Synchronises the outbound tags and passes a level only after it has
 stood for the minimum tag time. Assumes tags come from the channel.
*/
`timescale 1ns/1ns
`default_nettype none
module chrs_tag_qual #(
   parameter int MIN_CYC = chrs_pkg::TAG_MIN_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [chrs_pkg::NTAG-1:0] tag_raw,
   chrs_if.qual q
);
   import chrs_pkg::*;
   logic [NTAG-1:0] s1_q, s2_q;
   // Two-stage synchroniser; the first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      s1_q <= reset ? '0 : tag_raw;
      s2_q <= reset ? '0 : s1_q;
   end
   // One stability filter per tag
   for (genvar i = 0; i < NTAG; i++) begin : g_tag
      logic [7:0] cnt_q, cnt_d;
      logic lvl_q, lvl_d;
      always_comb begin
         cnt_d = 8'h00;
         lvl_d = lvl_q;
         if (s2_q[i] != lvl_q) begin
            cnt_d = cnt_q + 8'h01;
            if (cnt_q == 8'(MIN_CYC - 1)) begin
               lvl_d = s2_q[i];
               cnt_d = 8'h00;
            end
         end
      end
      always_ff @(posedge clk_sys) begin
         cnt_q <= reset ? 8'h00 : cnt_d;
         lvl_q <= reset ? 1'b0 : lvl_d;
      end
      assign q.tags[i] = lvl_q;
   end
endmodule
`default_nettype wire

// [src/chrs_stat_store.sv]
/*
 Holds one status byte from generation until accepted or reset, and
 marks it stacked once refused. Assumes the core offers it.
*/
`timescale 1ns/1ns
`default_nettype none
module chrs_stat_store (
   input wire logic clk_sys,
   input wire logic reset,
   chrs_if.store s
);
   import chrs_pkg::*;
   logic have_q, have_d, stk_q, stk_d, ovr_q, ovr_d;
   logic [7:0] held_q, held_d;
   // Acceptance wins over a new byte only for the byte it consumed
   always_comb begin
      have_d = have_q;
      stk_d = stk_q;
      held_d = held_q;
      ovr_d = ovr_q;
      if (s.accept) begin
         have_d = 1'b0;
         stk_d = 1'b0;
         held_d = 8'h00;
      end else if (s.stack) begin
         stk_d = 1'b1;
      end
      if (s.clear) begin
         have_d = 1'b0;
         stk_d = 1'b0;
         held_d = 8'h00;
      end
      if (s.gen) begin
         // Never merge into a held byte: that could change its meaning
         if (have_d) begin
            ovr_d = 1'b1;
         end else begin
            have_d = 1'b1;
            held_d = s.gen_bits;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      have_q <= reset ? 1'b0 : have_d;
      stk_q <= reset ? 1'b0 : stk_d;
      held_q <= reset ? 8'h00 : held_d;
      ovr_q <= reset ? 1'b0 : ovr_d;
   end
   assign s.have = have_q;
   assign s.stacked = stk_q;
   assign s.held = held_q;
   assign s.overrun = ovr_q;
endmodule
`default_nettype wire

// [bench/chrs_properties.sv]
/*
 Concurrent checks on the channel pins of chrs_top.
 Assumes it is bound to chrs_top and chrs_pkg is compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module chrs_properties (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic hold_out,
   input wire logic address_out,
   input wire logic suppress_out,
   input wire logic operational_out,
   input wire logic operational_in,
   input wire logic address_in,
   input wire logic status_in,
   input wire logic [8:0] bus_in
);
   localparam int DROP = chrs_pkg::DROP_MAX_CYC;
   logic [5:0] low_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Counts cycles with both reset tags low; saturates past the qualify time
   always_ff @(posedge clk_sys) begin
      if (reset || operational_out || suppress_out) begin
         low_q <= 6'h00;
      end else if (low_q != 6'h3F) begin
         low_q <= low_q + 6'h01;
      end
   end
   sequence s_disc;
      ($rose(address_out) && !hold_out) || ($fell(hold_out) && address_out);
   endsequence
   sequence s_selrst;
      $fell(operational_out) && suppress_out;
   endsequence
   a_disc_release: assert property (s_disc ##0 operational_in |-> ##[1:DROP] !operational_in)
      else $error("operational in held after disconnect");
   a_selrst_release: assert property (s_selrst ##0 operational_in |-> ##[1:DROP] !operational_in)
      else $error("operational in held after selective reset");
   a_sysrst_quiet: assert property (low_q == 6'h28 |-> !operational_in && bus_in == 9'h000)
      else $error("inbound lines up during system reset");
   a_inbound_connected: assert property ((status_in || address_in) |-> operational_in)
      else $error("inbound tag without operational in");
   a_byte_parity: assert property ((status_in || address_in) |-> ^bus_in)
      else $error("bus in parity is not odd");
   a_tags_exclusive: assert property (!(status_in && address_in))
      else $error("status in and address in together");
   a_bus_quiet: assert property (!(status_in || address_in) |-> bus_in == 9'h000)
      else $error("bus in driven with no inbound tag");
   a_status_held: assert property (status_in && $past(status_in) |-> $stable(bus_in))
      else $error("status byte changed while offered");
   a_wait_one: assert property (!hreadyout |=> hreadyout)
      else $error("wait state longer than one cycle");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
endmodule
`default_nettype wire

// [bench/chrs_chan_model.sv]
/*
 Behavioural channel: drives the outbound tags, offers tasks for
 selection, status service, disconnect and both resets.
 Assumes the bench calls one task at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module chrs_chan_model (
   input wire logic clk_sys,
   input wire logic operational_in,
   input wire logic address_in,
   input wire logic status_in,
   input wire logic request_in,
   input wire logic [8:0] bus_in,
   output logic select_out,
   output logic hold_out,
   output logic address_out,
   output logic command_out,
   output logic service_out,
   output logic suppress_out,
   output logic operational_out,
   output logic [7:0] bus_out
);
   localparam int GAP = 40;
   logic [3:0] ins;
   bit lost = 1'b0;
   assign ins = {request_in, status_in, address_in, operational_in};
   // Idle channel: both reset tags up, the rest down
   initial begin
      {select_out, hold_out, address_out, command_out, service_out} = 5'h00;
      suppress_out = 1'b1;
      operational_out = 1'b1;
      bus_out = 8'h00;
   end
   // Bounded wait for one inbound line; a miss is flagged for the bench
   task automatic wt(input int i, input logic v);
      int n;
      n = 0;
      while (ins[i] !== v && n < 900) begin
         @(posedge clk_sys);
         n++;
      end
      if (ins[i] !== v) lost = 1'b1;
   endtask
   task automatic connect();
      wt(3, 1'b1);
      @(posedge clk_sys);
      select_out <= 1'b1;
      hold_out <= 1'b1;
      wt(1, 1'b1);
   endtask
   // Accept with service out, stack with command out
   task automatic present(input bit acc, output logic [8:0] st);
      @(posedge clk_sys);
      command_out <= 1'b1;
      wt(1, 1'b0);
      @(posedge clk_sys);
      command_out <= 1'b0;
      wt(2, 1'b1);
      st = bus_in;
      @(posedge clk_sys);
      service_out <= acc;
      command_out <= !acc;
      wt(2, 1'b0);
      @(posedge clk_sys);
      {select_out, hold_out, command_out, service_out} <= 4'h0;
      wt(0, 1'b0);
      repeat (GAP) @(posedge clk_sys);
   endtask
   // Hold drops first, so the address rise alone signals the disconnect
   task automatic disconnect();
      @(posedge clk_sys);
      hold_out <= 1'b0;
      repeat (GAP) @(posedge clk_sys);
      address_out <= 1'b1;
      wt(0, 1'b0);
      @(posedge clk_sys);
      address_out <= 1'b0;
      select_out <= 1'b0;
      repeat (GAP) @(posedge clk_sys);
   endtask
   task automatic sel_reset();
      @(posedge clk_sys);
      operational_out <= 1'b0;
      wt(0, 1'b0);
      repeat (chrs_pkg::DROP_MAX_CYC) @(posedge clk_sys);
      operational_out <= 1'b1;
      {select_out, hold_out} <= 2'h0;
      repeat (GAP) @(posedge clk_sys);
   endtask
   task automatic sys_reset(input int len);
      @(posedge clk_sys);
      {operational_out, suppress_out} <= 2'h0;
      repeat (len) @(posedge clk_sys);
      {operational_out, suppress_out} <= 2'h3;
   endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
/*
 Self-checking bench for chrs_top with a channel model on the tags.
 Assumes chrs_pkg, the design and the model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import chrs_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, operational_in, address_in, status_in, request_in;
   logic select_out, hold_out, address_out, command_out, service_out;
   logic suppress_out, operational_out;
   logic [7:0] bus_out;
   logic [31:0] hrdata, rd;
   logic [8:0] bus_in, st;
   int errors = 0;
   int checks_done = 0;
   always #4 clk_sys = ~clk_sys;
   chrs_top dut_u (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .select_out(select_out), .hold_out(hold_out), .address_out(address_out),
      .command_out(command_out), .service_out(service_out), .suppress_out(suppress_out),
      .operational_out(operational_out), .bus_out(bus_out),
      .operational_in(operational_in), .address_in(address_in), .status_in(status_in),
      .request_in(request_in), .bus_in(bus_in));
   chrs_chan_model ch_u (.clk_sys(clk_sys), .operational_in(operational_in),
      .address_in(address_in), .status_in(status_in), .request_in(request_in),
      .bus_in(bus_in), .select_out(select_out), .hold_out(hold_out),
      .address_out(address_out), .command_out(command_out), .service_out(service_out),
      .suppress_out(suppress_out), .operational_out(operational_out), .bus_out(bus_out));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (ch_u.lost) errors++;
      if (errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Waits for hready high at an edge; a stuck slave ends the run
   task automatic wrdy();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         errors++;
         tally_and_finish();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      wrdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wrdy();
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   // Idle pins, register defaults and an unmapped word
   task automatic t_reset();
      chk({operational_in, address_in, status_in, request_in}, 32'h0);
      chk(bus_in, 32'h0);
      rdchk(OFS_STATE, 32'hFF, 32'h00);
      bus(1'b1, 8'h40, 32'hFFFF_FFFF);
      rdchk(8'h40, 32'hFFFF_FFFF, 32'h0);
   endtask
   // Ready transition makes a byte; stacked once, then accepted
   task automatic t_ready();
      bus(1'b1, OFS_DEVADR, 32'h3C);
      bus(1'b1, OFS_CTRL, 32'h3);
      rdchk(OFS_STATE, 32'hFF, 32'h44);
      ch_u.connect();
      chk(bus_in, 32'h13C);
      ch_u.present(1'b0, st);
      chk(st, 32'h1A5);
      rdchk(OFS_STATE, 32'h08, 32'h08);
      ch_u.connect();
      ch_u.present(1'b1, st);
      chk(st, 32'h1A5);
      rdchk(OFS_STATE, 32'hFF, 32'h40);
      chk(request_in, 32'h0);
   endtask
   // A second byte while one is held is refused, never merged
   task automatic t_over();
      bus(1'b1, OFS_GEN, 32'h80);
      bus(1'b1, OFS_GEN, 32'h02);
      rdchk(OFS_STATE, 32'hFF, 32'hC4);
      rdchk(OFS_SHOW, 32'h1FF, 32'h080);
      ch_u.connect();
      ch_u.present(1'b1, st);
      chk(st, 32'h080);
      rdchk(OFS_STATE, 32'h04, 32'h00);
   endtask
   // Disconnect mid-operation: lines drop, chaining clears, busy stays
   task automatic t_disc();
      bus(1'b1, OFS_CTRL, 32'h7);
      rdchk(OFS_STATE, 32'h12, 32'h12);
      bus(1'b1, OFS_GEN, 32'h08);
      ch_u.connect();
      ch_u.disconnect();
      chk({operational_in, address_in, status_in, bus_in}, 32'h0);
      rdchk(OFS_STATE, 32'h12, 32'h02);
      rdchk(OFS_SHOW, 32'h1FF, 32'h008);
      ch_u.connect();
      ch_u.present(1'b1, st);
      chk(st, 32'h008);
      bus(1'b1, OFS_GEN, 32'h04);
      ch_u.connect();
      ch_u.present(1'b1, st);
      chk(st, 32'h004);
      rdchk(OFS_STATE, 32'h02, 32'h00);
   endtask
   // Attention cancels chaining; selective reset drops the held byte
   task automatic t_sel();
      bus(1'b1, OFS_CTRL, 32'h7);
      bus(1'b1, OFS_GEN, 32'h80);
      rdchk(OFS_STATE, 32'h10, 32'h00);
      ch_u.connect();
      ch_u.sel_reset();
      chk(operational_in, 32'h0);
      rdchk(OFS_STATE, 32'h4C, 32'h40);
   endtask
   // System reset: busy while both tags low, ready state survives
   task automatic t_sys();
      bus(1'b1, OFS_GEN, 32'h80);
      fork
         ch_u.sys_reset(750);
         begin
            repeat (100) @(posedge clk_sys);
            rdchk(OFS_STATE, 32'h26, 32'h22);
         end
      join
      repeat (RST_BUSY_CYC + 40) @(posedge clk_sys);
      rdchk(OFS_STATE, 32'h7F, 32'h40);
   endtask
   // Main sequence: ten cycles of reset, then each scenario in turn
   initial begin
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (TAG_MIN_CYC + 8) @(posedge clk_sys);
      t_reset();
      t_ready();
      t_over();
      t_disc();
      t_sel();
      t_sys();
      tally_and_finish();
   end
endmodule
bind chrs_top chrs_properties chk_u (.clk_sys(clk_sys), .reset(reset),
   .hreadyout(hreadyout), .hresp(hresp), .hold_out(hold_out),
   .address_out(address_out), .suppress_out(suppress_out),
   .operational_out(operational_out), .operational_in(operational_in),
   .address_in(address_in), .status_in(status_in), .bus_in(bus_in));
`default_nettype wire
